// *** dlvm_params.svh ***
`ifndef DLVM_PARAMS_SVH
`define DLVM_PARAMS_SVH

// Width of one source sample and of one link word.
`define DLVM_SAMPLE_BITS 12
`define DLVM_WORD_BITS 10

// Samples per line for each picture rate, and the active image count.
`define DLVM_TOTAL_60 12'h898
`define DLVM_TOTAL_50 12'hA50
`define DLVM_TOTAL_24 12'hABE
`define DLVM_ACTIVE 12'h780

// Auxiliary word default, legal range and non-picture data mask.
`define DLVM_AUX_DEFAULT 10'h064
`define DLVM_AUX_MIN 10'h004
`define DLVM_AUX_MAX 10'h3FB
`define DLVM_AUX_DATA_MASK 10'h0FF

// Words sent when the source has nothing ready.
`define DLVM_IDLE_LUMA 10'h040
`define DLVM_IDLE_CHROMA 10'h200

// Bit positions inside a low-bit word.
`define DLVM_LOW_INV_BIT 9
`define DLVM_LOW_EP_BIT 8
`define DLVM_LOW_Y_BIT 6
`define DLVM_LOW_CB_BIT 4
`define DLVM_LOW_CR_BIT 2

// Reset values.
`define DLVM_RESET_WORD 10'h000
`define DLVM_RESET_SAMPLE 12'h000

`endif

// *** dlvm_pkg.sv ***
package dlvm_pkg;

   // Word slot within one sample pair, sent in this order on both links.
   typedef enum logic [1:0] {
      DLVM_PH_CB = 2'b00,
      DLVM_PH_Y0 = 2'b01,
      DLVM_PH_CR = 2'b10,
      DLVM_PH_Y1 = 2'b11
   } dlvm_phase_t;

   // Sample format carried by the two links.
   typedef enum logic {
      DLVM_MODE_422_12 = 1'b0,
      DLVM_MODE_444_10 = 1'b1
   } dlvm_mode_t;

   // Picture rate family, which sets the line length.
   typedef enum logic [1:0] {
      DLVM_RATE_60 = 2'b00,
      DLVM_RATE_50 = 2'b01,
      DLVM_RATE_24 = 2'b10
   } dlvm_rate_t;

   // Component slots inside one sample-pair word from the source.
   typedef enum logic [2:0] {
      DLVM_C_Y0 = 3'h0,
      DLVM_C_Y1 = 3'h1,
      DLVM_C_CB0 = 3'h2,
      DLVM_C_CB1 = 3'h3,
      DLVM_C_CR0 = 3'h4,
      DLVM_C_CR1 = 3'h5,
      DLVM_C_A0 = 3'h6,
      DLVM_C_A1 = 3'h7
   } dlvm_comp_t;

endpackage

// *** dlvm_fifo.sv ***
`timescale 1ns/1ns
`include "dlvm_params.svh"

// Small synchronous FIFO with a registered output stage.
module dlvm_fifo #(
   parameter int WIDTH = 96,
   parameter int DEPTH = 8
) (
   // Clock, reset and enable.
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Filling side.
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // Draining side.
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);

   localparam int AW = $clog2(DEPTH);

   // Depth must be a power of two of at least two for the pointers to wrap.
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_bad
      $error("dlvm_fifo: DEPTH must be a power of two >= 2");
   end

   // All state of the FIFO, storage included.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic room; // Set while a slot is free; drives the ready output directly.
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } dlvm_fifo_st_t;

   dlvm_fifo_st_t st;
   dlvm_fifo_st_t next_st;

   // Writes, output-stage loads and the occupancy count.
   always_comb
   begin
      logic do_wr;
      logic do_ld;
      do_wr = 1'b0;
      do_ld = 1'b0;
      next_st = st;
      do_wr = i_valid && st.room;
      do_ld = (st.count != '0) && (!st.out_valid || i_ready);
      if (do_wr)
      begin
         next_st.mem[st.wptr] = i_data;
         next_st.wptr = AW'(st.wptr + 1'b1);
      end
      // The output register refills as soon as it is consumed or empty.
      if (do_ld)
      begin
         next_st.out_data = st.mem[st.rptr];
         next_st.rptr = AW'(st.rptr + 1'b1);
         next_st.out_valid = 1'b1;
      end
      else if (i_ready)
      begin
         next_st.out_valid = 1'b0;
      end
      next_st.count = (AW+1)'(st.count + {AW'(0), do_wr} - {AW'(0), do_ld});
      next_st.room = (next_st.count != (AW+1)'(DEPTH));
   end

   // State register, frozen while the enable is low.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st <= '0;
         st.room <= 1'b1;
      end
      else if (i_ce)
      begin
         st <= next_st;
      end
   end

   assign o_ready = st.room;
   assign o_valid = st.out_valid;
   assign o_data = st.out_data;

endmodule

// *** dlvm_lowbit_word.sv ***
`timescale 1ns/1ns
`include "dlvm_params.svh"

// Builds one parity-protected word from the two low bits of the samples.
module dlvm_lowbit_word #(
   parameter bit LUMA_ONLY = 1'b0
) (
   // Low two bits of each component.
   input wire logic [1:0] i_y,
   input wire logic [1:0] i_cb,
   input wire logic [1:0] i_cr,
   // Finished word.
   output logic [9:0] o_word
);

   // Packs the fields, then adds the parity bit and its inverse.
   always_comb
   begin
      logic [7:0] body;
      body = 8'h00;
      body[`DLVM_LOW_Y_BIT +: 2] = i_y;
      if (!LUMA_ONLY)
      begin
         body[`DLVM_LOW_CB_BIT +: 2] = i_cb;
         body[`DLVM_LOW_CR_BIT +: 2] = i_cr;
      end
      o_word = {2'b00, body};
      o_word[`DLVM_LOW_EP_BIT] = ^body;
      o_word[`DLVM_LOW_INV_BIT] = ~(^body);
   end

endmodule

// *** dlvm_mapper.sv ***
`timescale 1ns/1ns
`include "dlvm_params.svh"

// Summary of operation
// - 4:2:2 luma line 2200/2640/2750 samples from zero.
// - 4:2:2 chroma lines are half the luma count.
// - Split each sample into upper ten, lower two.
// - 4:2:2 link A: all luma, even chroma.
// - 4:2:2 link B: low-bit words plus auxiliary.
// - Even low word: Y, Cb, Cr, reserved.
// - Odd low word: Y low bits, rest reserved.
// - Bit 8 gives even parity over 7..0.
// - Bit 9 is inverse of bit 8.
// - Reserved low-word bits are driven zero.
// - Link A order Cb, Y, Cr, Y.
// - 4:2:2 link B alternates auxiliary and low word.
// - 4:4:4 lines 2200/2640/2750 samples from zero.
// - 4:4:4 link A: all luma, even chroma.
// - 4:4:4 link B: odd chroma, all auxiliary.
// - 4:4:4 link B order Cb, A, Cr, A.
// - 1920 active words; 2200 or 2640 total.
// - 24 Hz lines have 2750 words, last 2749.
// - Absent auxiliary is sent as 64h.
// - Auxiliary avoids 000-003, 3FC-3FF; data 8 bits.
module dlvm_mapper
   import dlvm_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock, reset and enable.
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Configuration.
   input wire logic i_mode,
   input wire logic [1:0] i_rate,
   input wire logic i_aux_present,
   input wire logic i_aux_nonpicture,
   // Sample-pair stream from the video source.
   input wire logic i_valid,
   input wire logic [95:0] i_pair,
   output logic o_ready,
   // Word clock from the link side.
   input wire logic i_link_clk,
   // Link words and their timing.
   output logic [9:0] o_link_a,
   output logic [9:0] o_link_b,
   output logic o_word_valid,
   output logic [11:0] o_sample_num,
   output logic o_active,
   output logic o_line_start,
   output logic o_underrun
);

   localparam int PAIR_BITS = 8 * `DLVM_SAMPLE_BITS;

   // All state of the mapper.
   typedef struct packed {
      logic lk_s1;               // First synchroniser stage.
      logic lk_s2;               // Second synchroniser stage.
      logic lk_s3;               // Previous level for edge finding.
      dlvm_phase_t phase;        // Word slot sent at the next edge.
      logic [11:0] sample;       // Luma number n of the current pair.
      logic [PAIR_BITS-1:0] cur; // Pair held for slots two to four.
      logic [9:0] out_a;
      logic [9:0] out_b;
      logic out_valid;
      logic [11:0] out_sample;
      logic out_active;
      logic out_line_start;
      logic out_underrun;
      logic out_low;             // Link B word is a low-bit word.
      logic out_low_odd;         // That low-bit word is luma only.
      logic out_aux;             // Link B word is auxiliary.
   } dlvm_map_st_t;

   dlvm_map_st_t st;
   dlvm_map_st_t next_st;

   // FIFO draining side.
   logic f_valid;
   logic [PAIR_BITS-1:0] f_data;
   logic f_pop;
   // Pair in use this slot and derived words.
   logic [PAIR_BITS-1:0] src;
   logic [9:0] low_even;
   logic [9:0] low_odd;
   logic link_edge;
   logic [11:0] total;

   // Sample pairs are buffered so the source may run ahead of the link.
   dlvm_fifo #(
      .WIDTH(PAIR_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_valid(i_valid),
      .i_data(i_pair),
      .o_ready(o_ready),
      .o_valid(f_valid),
      .o_data(f_data),
      .i_ready(f_pop)
   );

   // Returns the twelve-bit component in the given slot of a pair.
   function automatic logic [11:0] comp(input logic [PAIR_BITS-1:0] p, input dlvm_comp_t c);
      comp = p[int'(c) * `DLVM_SAMPLE_BITS +: `DLVM_SAMPLE_BITS];
   endfunction

   // Upper ten bits of a component, the part carried as a whole word.
   function automatic logic [9:0] hi10(input logic [PAIR_BITS-1:0] p, input dlvm_comp_t c);
      logic [11:0] s;
      s = comp(p, c);
      hi10 = s[11:2];
   endfunction

   // Auxiliary word: default when absent, kept clear of the reserved codes.
   function automatic logic [9:0] aux_word(input logic [PAIR_BITS-1:0] p, input dlvm_comp_t c,
                                           input logic present, input logic nonpic);
      logic [9:0] v;
      v = hi10(p, c);
      if (nonpic)
      begin
         v = v & `DLVM_AUX_DATA_MASK;
      end
      if (v < `DLVM_AUX_MIN)
      begin
         v = `DLVM_AUX_MIN;
      end
      else if (v > `DLVM_AUX_MAX)
      begin
         v = `DLVM_AUX_MAX;
      end
      aux_word = present ? v : `DLVM_AUX_DEFAULT;
   endfunction

   // Low-bit word for even sample points: Y, Cb and Cr.
   dlvm_lowbit_word #(
      .LUMA_ONLY(1'b0)
   ) u_low_even (
      .i_y(src[int'(DLVM_C_Y0) * `DLVM_SAMPLE_BITS +: 2]),
      .i_cb(src[int'(DLVM_C_CB0) * `DLVM_SAMPLE_BITS +: 2]),
      .i_cr(src[int'(DLVM_C_CR0) * `DLVM_SAMPLE_BITS +: 2]),
      .o_word(low_even)
   );

   // Low-bit word for odd sample points: Y alone.
   dlvm_lowbit_word #(
      .LUMA_ONLY(1'b1)
   ) u_low_odd (
      .i_y(src[int'(DLVM_C_Y1) * `DLVM_SAMPLE_BITS +: 2]),
      .i_cb(2'b00),
      .i_cr(2'b00),
      .o_word(low_odd)
   );

   // Line length chosen by the picture rate; the spare code falls back to 2200.
   always_comb
   begin
      unique case (dlvm_rate_t'(i_rate))
         DLVM_RATE_60: total = `DLVM_TOTAL_60;
         DLVM_RATE_50: total = `DLVM_TOTAL_50;
         DLVM_RATE_24: total = `DLVM_TOTAL_24;
         default: total = `DLVM_TOTAL_60;
      endcase
   end

   // A new pair is taken only at the first slot, on a word-clock edge.
   assign link_edge = st.lk_s2 && !st.lk_s3;
   assign f_pop = link_edge && (st.phase == DLVM_PH_CB);

   // The first slot reads the FIFO head; idle words fill a starved link.
   always_comb
   begin
      if (st.phase != DLVM_PH_CB)
      begin
         src = st.cur;
      end
      else if (f_valid)
      begin
         src = f_data;
      end
      else
      begin
         src = '0;
         src[int'(DLVM_C_Y0) * 12 +: 12] = {`DLVM_IDLE_LUMA, 2'b00};
         src[int'(DLVM_C_Y1) * 12 +: 12] = {`DLVM_IDLE_LUMA, 2'b00};
         src[int'(DLVM_C_CB0) * 12 +: 12] = {`DLVM_IDLE_CHROMA, 2'b00};
         src[int'(DLVM_C_CB1) * 12 +: 12] = {`DLVM_IDLE_CHROMA, 2'b00};
         src[int'(DLVM_C_CR0) * 12 +: 12] = {`DLVM_IDLE_CHROMA, 2'b00};
         src[int'(DLVM_C_CR1) * 12 +: 12] = {`DLVM_IDLE_CHROMA, 2'b00};
         src[int'(DLVM_C_A0) * 12 +: 12] = {`DLVM_AUX_DEFAULT, 2'b00};
         src[int'(DLVM_C_A1) * 12 +: 12] = {`DLVM_AUX_DEFAULT, 2'b00};
      end
   end

   // Next-state logic: synchroniser, word slots, sample count and outputs.
   always_comb
   begin
      next_st = st;
      next_st.out_valid = 1'b0;
      next_st.out_line_start = 1'b0;
      next_st.out_underrun = 1'b0;
      // Only the second stage reads the first.
      next_st.lk_s1 = i_link_clk;
      next_st.lk_s2 = st.lk_s1;
      next_st.lk_s3 = st.lk_s2;
      if (link_edge)
      begin
         // Both links change on the same edge, word k beside word k.
         next_st.out_valid = 1'b1;
         next_st.out_low = 1'b0;
         next_st.out_low_odd = 1'b0;
         next_st.out_aux = 1'b0;
         next_st.out_sample = st.sample;
         next_st.out_active = (st.sample < `DLVM_ACTIVE);
         unique case (st.phase)
            DLVM_PH_CB:
            begin
               // Keep the pair for the rest of its slots.
               next_st.cur = src;
               next_st.out_underrun = !f_valid;
               next_st.out_line_start = (st.sample == `DLVM_RESET_SAMPLE);
               next_st.out_a = hi10(src, DLVM_C_CB0);
               if (dlvm_mode_t'(i_mode) == DLVM_MODE_422_12)
               begin
                  next_st.out_b = aux_word(src, DLVM_C_A0, i_aux_present,
                                           i_aux_nonpicture);
                  next_st.out_aux = 1'b1;
               end
               else
               begin
                  next_st.out_b = hi10(src, DLVM_C_CB1);
               end
               next_st.phase = DLVM_PH_Y0;
            end
            DLVM_PH_Y0:
            begin
               next_st.out_a = hi10(src, DLVM_C_Y0);
               if (dlvm_mode_t'(i_mode) == DLVM_MODE_422_12)
               begin
                  next_st.out_b = low_even;
                  next_st.out_low = 1'b1;
               end
               else
               begin
                  next_st.out_b = aux_word(src, DLVM_C_A0, i_aux_present,
                                           i_aux_nonpicture);
                  next_st.out_aux = 1'b1;
               end
               next_st.phase = DLVM_PH_CR;
            end
            DLVM_PH_CR:
            begin
               next_st.out_a = hi10(src, DLVM_C_CR0);
               if (dlvm_mode_t'(i_mode) == DLVM_MODE_422_12)
               begin
                  next_st.out_b = aux_word(src, DLVM_C_A1, i_aux_present,
                                           i_aux_nonpicture);
                  next_st.out_aux = 1'b1;
               end
               else
               begin
                  next_st.out_b = hi10(src, DLVM_C_CR1);
               end
               next_st.phase = DLVM_PH_Y1;
            end
            DLVM_PH_Y1:
            begin
               next_st.out_a = hi10(src, DLVM_C_Y1);
               next_st.out_sample = 12'(st.sample + 12'h001);
               next_st.out_active = (12'(st.sample + 12'h001) < `DLVM_ACTIVE);
               if (dlvm_mode_t'(i_mode) == DLVM_MODE_422_12)
               begin
                  next_st.out_b = low_odd;
                  next_st.out_low = 1'b1;
                  next_st.out_low_odd = 1'b1;
               end
               else
               begin
                  next_st.out_b = aux_word(src, DLVM_C_A1, i_aux_present,
                                           i_aux_nonpicture);
                  next_st.out_aux = 1'b1;
               end
               // Pairs advance the luma number by two; chroma counts at half.
               if (12'(st.sample + 12'h002) >= total)
               begin
                  next_st.sample = `DLVM_RESET_SAMPLE;
               end
               else
               begin
                  next_st.sample = 12'(st.sample + 12'h002);
               end
               next_st.phase = DLVM_PH_CB;
            end
         endcase
      end
   end

   // State register, frozen while the enable is low.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st <= '0;
      end
      else if (i_ce)
      begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign o_link_a = st.out_a;
   assign o_link_b = st.out_b;
   assign o_word_valid = st.out_valid;
   assign o_sample_num = st.out_sample;
   assign o_active = st.out_active;
   assign o_line_start = st.out_line_start;
   assign o_underrun = st.out_underrun;

   // Checks of the link words against the mapping.
   default clocking dlvm_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   // Low-bit words carry even parity in bit 8.
   low_parity_a: assert property (o_word_valid && st.out_low |-> ^o_link_b[8:0] == 1'b0)
      else $error("low-bit word parity is odd");
   // Bit 9 of a low-bit word is the inverse of bit 8.
   low_inverse_a: assert property (o_word_valid && st.out_low |-> o_link_b[9] != o_link_b[8])
      else $error("low-bit word bit 9 equals bit 8");

   // Reserved positions read zero in both low-bit forms.
   low_reserved_a: assert property (o_word_valid && st.out_low |->
      (o_link_b[1:0] == 2'b00) && (!st.out_low_odd || o_link_b[5:2] == 4'h0))
      else $error("reserved low-bit position is set");
   // With no auxiliary signal, the auxiliary slot holds the default.
   aux_default_a: assert property (o_word_valid && st.out_aux && !$past(i_aux_present) |->
      o_link_b == `DLVM_AUX_DEFAULT)
      else $error("absent auxiliary word is not the default");

   // Auxiliary words never use the reserved codes.
   aux_range_a: assert property (o_word_valid && st.out_aux |->
      o_link_b >= `DLVM_AUX_MIN && o_link_b <= `DLVM_AUX_MAX)
      else $error("auxiliary word in reserved range");
   // Sample numbers stay inside the longest line.
   sample_bound_a: assert property (o_word_valid |-> o_sample_num < `DLVM_TOTAL_24)
      else $error("sample number beyond line length");

   // Active flag marks exactly the first 1920 samples.
   active_flag_a: assert property (o_word_valid |-> o_active == (o_sample_num < `DLVM_ACTIVE))
      else $error("active flag disagrees with sample number");
   // A word strobe lasts one cycle and is followed by a gap.
   strobe_single_a: assert property (o_word_valid |=> !o_word_valid)
      else $error("word strobe held for two cycles");

   // 4:4:4 mode never sends a low-bit word.
   mode_444_a: assert property (o_word_valid && $past(i_mode) |-> !st.out_low)
      else $error("low-bit word sent in 4:4:4 mode");
   // A line begins at a pair whose number is zero.
   line_start_a: assert property (o_line_start |-> o_word_valid && o_sample_num == 12'h000)
      else $error("line start away from sample zero");

endmodule

// *** dlvm_link_partner.sv ***
`timescale 1ns/1ns

// Far-side model: makes the word clock and checks low-bit words like a receiver.
module dlvm_link_partner
   import dlvm_pkg::*;
(
   // Bench control.
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic i_mode,
   // Words from the mapper.
   input wire logic [9:0] i_link_b,
   input wire logic i_word_valid,
   input wire logic i_line_start,
   // Word clock and receiver status.
   output logic o_link_clk,
   output logic o_parity_err
);
   logic [1:0] slot; // Slot of the next word.
   logic [1:0] s; // Slot of the current word.

   // The word clock runs only while traffic is wanted, so it rests low between runs.
   initial
   begin
      o_link_clk = 1'b0;
      #13;
      forever
      begin
         if (i_run)
         begin
            o_link_clk = 1'b1;
            #400;
            o_link_clk = 1'b0;
            #400;
         end
         else
         begin
            #100;
         end
      end
   end

   // Low-bit words sit in slots 1 and 3; their parity and inverse bit are checked.
   initial
   begin
      slot = 2'h0;
      o_parity_err = 1'b0;
   end
   always @(negedge i_clk)
   begin
      if (i_word_valid)
      begin
         s = i_line_start ? 2'h0 : slot;
         if (i_mode == DLVM_MODE_422_12 && s[0] && (^i_link_b[8:0] || i_link_b[9] == i_link_b[8]))
         begin
            o_parity_err = 1'b1;
         end
         slot = s + 2'h1;
      end
   end
endmodule

// *** dlvm_mapper_test.sv ***
`timescale 1ns/1ns

// Self-checking bench for the dual-link word mapper.
module dlvm_mapper_test
   import dlvm_pkg::*;
;
   logic i_clk, i_resetn, i_mode, i_aux_present, i_aux_nonpicture, i_valid, run, rdy_s, under;
   logic [1:0] i_rate;
   logic [95:0] i_pair, cur, nxt;
   logic o_ready, link_clk, o_word_valid, o_active, o_line_start, o_underrun, par_err;
   logic [9:0] o_link_a, o_link_b, ea, eb;
   logic [11:0] o_sample_num, sn;
   logic [31:0] lfsr = 32'h3638; // Random source state.
   logic [95:0] exp_q[$]; // Pairs taken by the mapper, oldest first.
   int miscompares, compares, to_send, slot, n, unders, words;

   dlvm_mapper #(.FIFO_DEPTH(8)) i_dlvm_mapper (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1),
      .i_mode(i_mode), .i_rate(i_rate), .i_aux_present(i_aux_present),
      .i_aux_nonpicture(i_aux_nonpicture), .i_valid(i_valid), .i_pair(i_pair), .o_ready(o_ready),
      .i_link_clk(link_clk), .o_link_a(o_link_a), .o_link_b(o_link_b),
      .o_word_valid(o_word_valid), .o_sample_num(o_sample_num), .o_active(o_active),
      .o_line_start(o_line_start), .o_underrun(o_underrun));
   dlvm_link_partner i_dlvm_link_partner (.i_clk(i_clk), .i_run(run), .i_mode(i_mode),
      .i_link_b(o_link_b), .i_word_valid(o_word_valid), .i_line_start(o_line_start),
      .o_link_clk(link_clk), .o_parity_err(par_err));

   // Next value of the shift register.
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   // Auxiliary word: masked, clamped, or the default when absent.
   function automatic logic [9:0] aux_word(input logic [11:0] s);
      logic [9:0] v;
      v = i_aux_nonpicture ? (s[11:2] & 10'h0FF) : s[11:2];
      if (!i_aux_present) v = 10'h064;
      else if (v < 10'h004) v = 10'h004;
      else if (v > 10'h3FB) v = 10'h3FB;
      return v;
   endfunction

   // Low-bit word with even parity in bit 8 and its inverse in bit 9.
   function automatic logic [9:0] low_word(input logic [11:0] y, cb, cr, input logic odd);
      logic [7:0] b;
      b = {y[1:0], odd ? 6'h00 : {cb[1:0], cr[1:0], 2'h0}};
      return {~(^b), ^b, b};
   endfunction

   // Counts one comparison and reports a mismatch.
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Clock at 100 ns.
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // Source feeding and word checking share one process so the queue is never raced.
   always @(negedge i_clk)
   begin
      if (i_valid && rdy_s) exp_q.push_back(i_pair);
      if (!(i_valid && !rdy_s))
      begin
         if (to_send > 0 && rnd() % 4 != 0)
         begin
            // Build the pair aside so each input changes once per edge.
            nxt = {rnd(), rnd(), rnd()};
            if (to_send % 37 == 0) nxt[95:72] = 24'hFFF000;
            i_pair = nxt;
            i_valid = 1'b1;
            to_send--;
         end
         else
            i_valid = 1'b0;
      end
      rdy_s = o_ready;
      if (i_resetn && o_word_valid)
      begin
         words++;
         if (slot == 0)
         begin
            under = exp_q.size() == 0;
            unders += under;
            cur = under ? {12'h190, 12'h190, {4{12'h800}}, 12'h100, 12'h100} : exp_q.pop_front();
            check(o_underrun, under, "underrun");
         end
         ea = slot == 0 ? cur[35:26] : slot == 1 ? cur[11:2] : slot == 2 ? cur[59:50] : cur[23:14];
         if (i_mode == DLVM_MODE_422_12)
            eb = slot[0] ? low_word(slot == 1 ? cur[11:0] : cur[23:12], cur[35:24], cur[59:48],
               slot == 3) : aux_word(slot == 0 ? cur[83:72] : cur[95:84]);
         else
            eb = slot == 0 ? cur[47:38] : slot == 2 ? cur[71:62] :
               aux_word(slot == 1 ? cur[83:72] : cur[95:84]);
         sn = 12'(slot == 3 ? n + 1 : n);
         check(o_link_a, ea, "link a");
         check(o_link_b, eb, "link b");
         check(o_sample_num, sn, "sample");
         check(o_active, sn < 12'd1920, "active");
         check(o_line_start, slot == 0 && n == 0, "line start");
         if (slot == 3)
         begin
            n += 2;
            if (n >= (i_rate == 2'h1 ? 2640 : i_rate == 2'h2 ? 2750 : 2200)) n = 0;
         end
         slot = (slot + 1) % 4;
      end
   end

   // Runs the word clock for a number of words, then lets the last word land.
   task automatic run_words(input int words);
      run = 1'b1;
      repeat (words) @(posedge link_clk);
      run = 1'b0;
      repeat (16) @(negedge i_clk);
   endtask

   // Main sequence.
   initial
   begin
      {i_resetn, i_mode, i_aux_nonpicture, i_valid, run, rdy_s} = 6'h00;
      {i_rate, i_aux_present, i_pair} = {2'h2, 1'b1, 96'h0};
      {to_send, slot, n, unders, words, miscompares, compares} = 224'h0;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      i_resetn = 1'b1;
      // Link stopped: the buffer takes eight entries plus its output register.
      to_send = 100000;
      repeat (60) @(negedge i_clk);
      check(16'(exp_q.size()), 16'd9, "fill level");
      check(o_ready, 1'b0, "full");
      $display("Fill test done");
      // One whole 2750-sample line in 4:2:2 and the wrap to sample zero.
      run_words(5502);
      $display("Line test done");
      // Source stops: the buffer drains and idle pairs follow.
      to_send = 0;
      run_words(80);
      check(unders > 0, 1'b1, "drain");
      $display("Drain test done");
      // 4:4:4 with eight-bit auxiliary data, then with auxiliary absent.
      {i_mode, i_rate, i_aux_nonpicture} = {DLVM_MODE_444_10, 2'h1, 1'b1};
      to_send = 100000;
      repeat (40) @(negedge i_clk);
      run_words(300);
      {i_aux_present, i_rate} = {1'b0, 2'h3};
      run_words(300);
      check(par_err, 1'b0, "receiver parity");
      check(16'(words), 16'd6182, "word count");
      $display("Mode test done");
      final_report();
   end

   // Watchdog set well beyond the expected run of about 5 ms.
   initial
   begin
      #9000000;
      miscompares++;
      final_report();
   end
endmodule
